// ---- design/fifo_threshold_pkg.sv ----
package fifo_threshold_pkg;
  // ****************************************
  // Register map
  // ****************************************
  localparam logic [5:0] FIFO_THRESHOLD_CONTROL_ADDR = 6'h03;
  localparam logic [7:0] FIFO_THRESHOLD_CONTROL_RST  = 8'h07;
  localparam int         RESERVED_BIT                = 7;
  localparam int         WAKE_TRIM_BIT               = 6;
  localparam int         ATTEN_MSB                   = 5;
  localparam int         ATTEN_LSB                   = 4;
  localparam int         LEVEL_MSB                   = 3;
  localparam int         LEVEL_LSB                   = 0;
  // ****************************************
  // Wake trim values
  // ****************************************
  localparam logic [7:0] TRIM_A_CLEAR = 8'h31;
  localparam logic [7:0] TRIM_B_CLEAR = 8'h88;
  localparam logic [7:0] TRIM_A_SET   = 8'h35;
  localparam logic [7:0] TRIM_B_SET   = 8'h81;
  // ****************************************
  // Threshold arithmetic
  // ****************************************
  localparam logic [6:0] TX_BASE    = 7'h3D;
  localparam logic [6:0] STEP       = 7'h04;
  localparam logic [6:0] TX_LAST    = 7'h01;
  localparam logic [3:0] LEVEL_LAST = 4'hF;
  // Attenuation in dB per step of the close-in field
  localparam logic [4:0] ATTEN_STEP_DB = 5'h06;
endpackage : fifo_threshold_pkg

// ---- design/level_compare.sv ----
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Registered fill level comparison
// ****************************************
module level_compare (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic [6:0] fillCount,
  input  wire logic [6:0] threshold,
  output var  logic       reached
);
  // Reached when count at or above threshold
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      reached <= 1'b0;
    else
      reached <= (fillCount >= threshold);
  end
endmodule : level_compare
`default_nettype wire

// ---- design/fifo_threshold_config.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_threshold_config (
  input  wire logic       clk,
  input  wire logic       rstn,
  input  wire logic       regWrite,
  input  wire logic [5:0] regAddr,
  input  wire logic [7:0] regWriteData,
  output var  logic [7:0] regReadData,
  input  wire logic       wakeEvent,
  input  wire logic [6:0] txFillCount,
  input  wire logic [6:0] rxFillCount,
  output var  logic [7:0] analogTrimA,
  output var  logic [7:0] analogTrimB,
  output var  logic       trimLoad,
  output var  logic [1:0] rxAttenSelect,
  output var  logic [4:0] rxAttenDb,
  output var  logic [6:0] txThreshold,
  output var  logic [6:0] rxThreshold,
  output var  logic       txThresholdReached,
  output var  logic       rxThresholdReached
);
  // ****************************************
  // Register
  // ****************************************
  logic [7:0]      fifo_threshold_control;
  logic            addrHit;
  logic            wake_trim_select;
  logic [1:0]      closeInRx;
  logic [3:0]      fifo_level_select;
  logic [6:0]      nextTxThreshold;
  logic [6:0]      nextRxThreshold;
  logic [1:0][6:0] fillPair;
  logic [1:0][6:0] levelPair;
  wire logic [1:0] reachedPair;

  assign addrHit           = (regAddr == fifo_threshold_pkg::FIFO_THRESHOLD_CONTROL_ADDR);
  assign wake_trim_select  = fifo_threshold_control[fifo_threshold_pkg::WAKE_TRIM_BIT];
  assign closeInRx         = fifo_threshold_control[fifo_threshold_pkg::ATTEN_MSB:fifo_threshold_pkg::ATTEN_LSB];
  assign fifo_level_select = fifo_threshold_control[fifo_threshold_pkg::LEVEL_MSB:fifo_threshold_pkg::LEVEL_LSB];

  // Register write, whole byte stored
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      fifo_threshold_control <= fifo_threshold_pkg::FIFO_THRESHOLD_CONTROL_RST;
    else if (regWrite && addrHit)
      fifo_threshold_control <= regWriteData;
  end

  // Registered read data, zero elsewhere
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      regReadData <= 8'h00;
    else
      regReadData <= addrHit ? fifo_threshold_control : 8'h00;
  end

  // ****************************************
  // Wake trim load
  // ****************************************
  // Set or clear trim word, chosen by the retention bit
  function automatic logic [7:0] wakeTrim(
    input logic       keepSet,
    input logic [7:0] setWord,
    input logic [7:0] clearWord
  );
    if (keepSet)
      wakeTrim = setWord;
    else
      wakeTrim = clearWord;
  endfunction : wakeTrim

  // Load pulse one cycle after each wake
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      trimLoad <= 1'h0;
    end
    else
    begin
      trimLoad <= wakeEvent;
    end
  end

  // First analog setting; only the analog side ever sees it
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      analogTrimA <= fifo_threshold_pkg::TRIM_A_CLEAR;
    end
    else if (wakeEvent)
    begin
      analogTrimA <= wakeTrim(wake_trim_select,
                              fifo_threshold_pkg::TRIM_A_SET,
                              fifo_threshold_pkg::TRIM_A_CLEAR);
    end
  end

  // Second analog setting, loaded on the same wake edge
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      analogTrimB <= fifo_threshold_pkg::TRIM_B_CLEAR;
    end
    else if (wakeEvent)
    begin
      analogTrimB <= wakeTrim(wake_trim_select,
                              fifo_threshold_pkg::TRIM_B_SET,
                              fifo_threshold_pkg::TRIM_B_CLEAR);
    end
  end

  // ****************************************
  // Attenuation
  // ****************************************
  // Typical attenuation in dB for one close-in code
  function automatic logic [4:0] attenLevel(input logic [1:0] code);
    attenLevel = 5'({3'h0, code} * fifo_threshold_pkg::ATTEN_STEP_DB);
  endfunction : attenLevel

  // Close-in code passed to the receiver
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxAttenSelect <= 2'h0;
    end
    else
    begin
      rxAttenSelect <= closeInRx;
    end
  end

  // Attenuation figure for the same code
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxAttenDb <= 5'h00;
    end
    else
    begin
      rxAttenDb <= attenLevel(closeInRx);
    end
  end

  // ****************************************
  // Thresholds
  // ****************************************
  // Transmit threshold; last setting continues the pattern at one byte
  function automatic logic [6:0] txLevel(input logic [3:0] n);
    if (n == fifo_threshold_pkg::LEVEL_LAST)
      txLevel = fifo_threshold_pkg::TX_LAST;
    else
      txLevel = 7'(fifo_threshold_pkg::TX_BASE - 7'({3'h0, n} * fifo_threshold_pkg::STEP));
  endfunction : txLevel

  // Receive threshold, four bytes per step up to a full FIFO
  function automatic logic [6:0] rxLevel(input logic [3:0] n);
    rxLevel = 7'(7'({3'h0, n} + 7'h01) * fifo_threshold_pkg::STEP);
  endfunction : rxLevel

  // Thresholds for the current level field
  assign nextTxThreshold = txLevel(fifo_level_select);
  assign nextRxThreshold = rxLevel(fifo_level_select);

  // Transmit threshold, one cycle behind the register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      txThreshold <= 7'h00;
    end
    else
    begin
      txThreshold <= nextTxThreshold;
    end
  end

  // Receive threshold, one cycle behind the register
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      rxThreshold <= 7'h00;
    end
    else
    begin
      rxThreshold <= nextRxThreshold;
    end
  end

  // ****************************************
  // Comparators
  // ****************************************
  // Index 0 transmit, index 1 receive
  assign fillPair  = {rxFillCount, txFillCount};
  assign levelPair = {nextRxThreshold, nextTxThreshold};

  // One registered comparator per FIFO
  for (genvar i = 0; i < 2; i++)
  begin : gCompare
    level_compare levelCheck (
      .clk       (clk),
      .rstn      (rstn),
      .fillCount (fillPair[i]),
      .threshold (levelPair[i]),
      .reached   (reachedPair[i])
    );
  end

  // Reached flags out
  assign txThresholdReached = reachedPair[0];
  assign rxThresholdReached = reachedPair[1];
endmodule : fifo_threshold_config
`default_nettype wire

// ---- tb/fifo_threshold_config_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// **********
// Port checks
// **********
module fifo_threshold_config_assertions (
  input wire logic       clk,
  input wire logic       rstn,
  input wire logic       regWrite,
  input wire logic [5:0] regAddr,
  input wire logic [7:0] regWriteData,
  input wire logic       wakeEvent,
  input wire logic [6:0] txFillCount,
  input wire logic [6:0] rxFillCount,
  input wire logic [7:0] analogTrimA,
  input wire logic [7:0] analogTrimB,
  input wire logic       trimLoad,
  input wire logic [1:0] rxAttenSelect,
  input wire logic [4:0] rxAttenDb,
  input wire logic [6:0] txThreshold,
  input wire logic [6:0] rxThreshold,
  input wire logic       txThresholdReached,
  input wire logic       rxThresholdReached
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  logic keep;
  logic wr;
  assign wr = regWrite && regAddr == 6'h03;
  // Mirror of the wake trim bit
  always_ff @(posedge clk or negedge rstn)
    if (!rstn) keep <= 1'b0;
    else if (wr) keep <= regWriteData[6];
  rx_map_a: assert property (wr |=> ##1 rxThreshold == {1'b0, $past(regWriteData[3:0], 2), 2'b00} + 7'h04)
    else $error("rx threshold wrong");
  sum_map_a: assert property ($past(rstn) |-> txThreshold + rxThreshold == 7'h41)
    else $error("tx threshold wrong");
  atten_sel_a: assert property (wr |=> ##1 rxAttenSelect == $past(regWriteData[5:4], 2))
    else $error("atten code wrong");
  atten_db_a: assert property (rxAttenDb == 5'(rxAttenSelect) * 5'h06)
    else $error("atten dB wrong");
  trim_load_a: assert property (wakeEvent |=> trimLoad && analogTrimA == ($past(keep) ? 8'h35 : 8'h31))
    else $error("wake trim wrong");
  trim_b_load_a: assert property (wakeEvent |=> analogTrimB == ($past(keep) ? 8'h81 : 8'h88))
    else $error("wake trim b wrong");
  trim_hold_a: assert property (!wakeEvent |=> !trimLoad && $stable(analogTrimA))
    else $error("trim moved");
  tx_reach_a: assert property (($stable(txFillCount) && $stable(txThreshold))[*3]
    |-> txThresholdReached == (txFillCount >= txThreshold)) else $error("tx level wrong");
  rx_reach_a: assert property (($stable(rxFillCount) && $stable(rxThreshold))[*3]
    |-> rxThresholdReached == (rxFillCount >= rxThreshold)) else $error("rx level wrong");
  cover property (wakeEvent && keep);
  cover property (wr && regWriteData[3:0] == 4'hF);
  cover property (txThresholdReached && !rxThresholdReached);
endmodule : fifo_threshold_config_assertions
bind fifo_threshold_config fifo_threshold_config_assertions chk (.clk, .rstn, .regWrite, .regAddr, .regWriteData,
  .wakeEvent, .txFillCount, .rxFillCount, .analogTrimA, .analogTrimB, .trimLoad, .rxAttenSelect, .rxAttenDb,
  .txThreshold, .rxThreshold, .txThresholdReached, .rxThresholdReached);
`default_nettype wire

// ---- tb/fifo_threshold_config_tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none
module fifo_threshold_config_tb_top;
  logic clk = 0, rstn = 0, regWrite = 0, wakeEvent = 0, trimLoad, txThresholdReached, rxThresholdReached;
  logic [5:0] regAddr = 6'h03;
  logic [7:0] regWriteData = 8'h00, regReadData, analogTrimA, analogTrimB;
  logic [6:0] txFillCount = 7'h00, rxFillCount = 7'h00, txThreshold, rxThreshold;
  logic [1:0] rxAttenSelect;
  logic [4:0] rxAttenDb;
  int fails = 0, samples_checked = 0, cyc = 0;
  fifo_threshold_config uut (.clk, .rstn, .regWrite, .regAddr, .regWriteData, .regReadData, .wakeEvent,
    .txFillCount, .rxFillCount, .analogTrimA, .analogTrimB, .trimLoad, .rxAttenSelect, .rxAttenDb,
    .txThreshold, .rxThreshold, .txThresholdReached, .rxThresholdReached);
  // Clock and hang guard
  initial forever #12.5 clk = ~clk;
  always @(posedge clk) if (++cyc > 2000)
  begin
    fails++;
    end_sim();
  end
  task automatic chk(string nm, logic [7:0] exp, logic [7:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %s exp %h got %h", nm, exp, got);
    end
  endtask : chk
  task automatic wr(logic [7:0] d);
    @(negedge clk) regWrite = 1; regWriteData = d;
    @(negedge clk) regWrite = 0;
    repeat (3) @(negedge clk);
  endtask : wr
  task automatic t_other;
    @(negedge clk) regAddr = 6'h04;
    wr(8'h0F);
    chk("otherRead", 8'h00, regReadData);
    chk("otherTx", 8'h21, {1'b0, txThreshold});
    @(negedge clk) regAddr = 6'h03;
    @(negedge clk);
    chk("keptReg", 8'h07, regReadData);
    $display("address test done");
  endtask : t_other
  task automatic t_map;
    for (int n = 0; n < 16; n++)
    begin
      wr({2'b00, 2'(n), 4'(n)});
      chk("read", {2'b00, 2'(n), 4'(n)}, regReadData);
      chk("sel", 8'(n % 4), {6'b0, rxAttenSelect});
      chk("tx", n == 15 ? 8'h01 : 8'(61 - 4 * n), {1'b0, txThreshold});
      chk("rx", 8'(4 * n + 4), {1'b0, rxThreshold});
      chk("db", 8'(6 * (n % 4)), {3'b0, rxAttenDb});
    end
    $display("map test done");
  endtask : t_map
  task automatic t_wake;
    for (int r = 1; r >= 0; r--)
    begin
      wr({1'b0, 1'(r), 6'h07});
      @(negedge clk) wakeEvent = 1;
      @(negedge clk) wakeEvent = 0;
      chk("load", 8'h01, {7'b0, trimLoad});
      chk("trimA", r ? 8'h35 : 8'h31, analogTrimA);
      chk("trimB", r ? 8'h81 : 8'h88, analogTrimB);
      @(negedge clk);
      chk("loadEnd", 8'h00, {7'b0, trimLoad});
      chk("regKept", {1'b0, 1'(r), 6'h07}, regReadData);
    end
    $display("wake test done");
  endtask : t_wake
  task automatic t_reach;
    int s;
    int txT;
    int rxT;
    for (int i = 0; i < 3; i++)
    begin
      s = (i == 0) ? 0 : (i == 1) ? 7 : 15;
      txT = (s == 15) ? 1 : 61 - 4 * s;
      rxT = 4 * s + 4;
      wr({4'h0, 4'(s)});
      for (int k = 0; k < 2; k++)
      begin
        txFillCount = 7'(txT - k);
        rxFillCount = 7'(rxT - 1 + k);
        repeat (3) @(negedge clk);
        chk("txHit", 8'(1 - k), {7'b0, txThresholdReached});
        chk("rxHit", 8'(k), {7'b0, rxThresholdReached});
      end
    end
    $display("level test done");
  endtask : t_reach
  task automatic end_sim;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : end_sim
  // Main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    rstn = 1;
    repeat (2) @(negedge clk);
    chk("reg", 8'h07, regReadData);
    chk("rstTx", 8'h21, {1'b0, txThreshold});
    chk("rstRx", 8'h20, {1'b0, rxThreshold});
    chk("rstTrimA", 8'h31, analogTrimA);
    chk("rstTrimB", 8'h88, analogTrimB);
    t_other();
    t_map();
    t_wake();
    t_reach();
    end_sim();
  end
endmodule : fifo_threshold_config_tb_top
`default_nettype wire
